//--- pkg/pfm_pkg.sv
/*
  Package for the pad function multiplexer: pin counts, field layouts,
  reset values and the per-pin configuration struct.
  Assumes a single system clock and no register bus.
*/
package pfm_pkg;
  localparam int NUM_PINS = 8;
  localparam int NUM_FUNCS = 4;
  localparam int NUM_SEL_INPUTS = 2;
  localparam int PAD_SEL_W = 3;
  localparam int ALT_W = 2;
  localparam int AN_ALIAS_W = 4;
  localparam logic [ALT_W-1:0] PRIMARY_FUNCTION = 2'h0;
  localparam logic [ALT_W-1:0] ALT_FUNC_1 = 2'h1;
  localparam logic [ALT_W-1:0] ALT_FUNC_2 = 2'h2;
  localparam logic [ALT_W-1:0] ALT_FUNC_3 = 2'h3;
  localparam logic SLEW_SLOW = 1'h0;
  localparam logic SLEW_MEDIUM = 1'h1;
  localparam logic [PAD_SEL_W-1:0] PAD_SEL_RESET = 3'h0;
  // Pin 6 and 7 input-only, carrying second converter aliases
  localparam logic [NUM_PINS-1:0] INPUT_ONLY_MASK = 8'hc0;
  // Bit per function code: 1 where an output function exists
  // Nibble per pin, pin 0 lowest; codes 2 and 3 empty on pin 2
  localparam logic [NUM_PINS*NUM_FUNCS-1:0] FUNC_PRESENT = 32'h11d5_f3ff;
  // First converter channel seen on the second converter's channels
  localparam logic [AN_ALIAS_W-1:0] AN_ALIAS_BASE = 4'h6;
  localparam int NUM_AN_ALIAS = 2;
  localparam int AN_ALIAS_FIRST_PIN = 6;

  typedef struct packed {
    logic [ALT_W-1:0] alt_select_field;
    logic input_buffer_enable;
    logic slew_rate_ctrl;
  } pfm_pad_cfg_t;

  typedef struct packed {
    logic out_val;
    logic out_en;
  } pfm_func_out_t;
endpackage : pfm_pkg

//--- rtl/pfm_pin_cell.sv
/*
  One pad's output selector and input gate.
  Assumes configuration already registered in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_cell (
  input wire pfm_pkg::pfm_pad_cfg_t cfg,
  input wire logic [pfm_pkg::NUM_FUNCS-1:0] func_present,
  input wire logic input_only,
  input wire pfm_pkg::pfm_func_out_t [pfm_pkg::NUM_FUNCS-1:0] func_out,
  input wire logic pad_in_sync,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_slew_medium,
  output logic pad_in_gated
);
  wire pfm_pkg::pfm_func_out_t sel_out;
  wire logic code_present;
  wire logic drive;
  assign sel_out = func_out[cfg.alt_select_field];
  assign code_present = func_present[cfg.alt_select_field];
  assign drive = sel_out.out_en & code_present & ~input_only;
  assign pad_out = drive & sel_out.out_val;
  assign pad_oe_n = ~drive;
  assign pad_slew_medium = ~input_only &
                           (cfg.slew_rate_ctrl == pfm_pkg::SLEW_MEDIUM);
  assign pad_in_gated = cfg.input_buffer_enable & pad_in_sync;
endmodule : pfm_pin_cell
`default_nettype wire

//--- rtl/pfm_pad_mux.sv
/*
  Pad function multiplexer top: config registers, input synchronisers,
  input fan-out, source selection and converter channel aliasing.
  Assumes pads sampled asynchronously; config written via plain ports.
*/
// Contract
// - Reset selects primary function on every pin
// - Two-bit code picks one of four functions
// - Code steers output path only
// - Input buffer enable passes input, any code
// - Input-only functions have no select code
// - Pad input reaches every consumer at once
// - Per-input pad select chooses source pad
// - Slew bit: zero slow, one medium; input-only pins 6 and 7 stay slow
// - First converter pins alias second's channels
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_mux (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfg_wr_en,
  input wire logic [2:0] cfg_wr_pin,
  input wire pfm_pkg::pfm_pad_cfg_t cfg_wr_data,
  input wire logic sel_wr_en,
  input wire logic sel_wr_idx,
  input wire logic [pfm_pkg::PAD_SEL_W-1:0] sel_wr_data,
  input wire pfm_pkg::pfm_func_out_t
    [pfm_pkg::NUM_PINS*pfm_pkg::NUM_FUNCS-1:0] func_out,
  input wire logic [pfm_pkg::NUM_PINS-1:0] pad_in,
  output logic [pfm_pkg::NUM_PINS-1:0] pad_out,
  output logic [pfm_pkg::NUM_PINS-1:0] pad_oe_n,
  output logic [pfm_pkg::NUM_PINS-1:0] pad_slew_medium,
  output logic [pfm_pkg::NUM_PINS-1:0] periph_in,
  output logic [pfm_pkg::NUM_SEL_INPUTS-1:0] sel_periph_in,
  input wire logic [pfm_pkg::AN_ALIAS_W-1:0] adc2_channel,
  output logic adc2_alias_valid,
  output logic [pfm_pkg::AN_ALIAS_W-1:0] adc1_channel
);
  localparam int NP = pfm_pkg::NUM_PINS;
  localparam int NF = pfm_pkg::NUM_FUNCS;

  pfm_pkg::pfm_pad_cfg_t [NP-1:0] cfg_reg;
  logic [pfm_pkg::PAD_SEL_W-1:0] sel_reg [pfm_pkg::NUM_SEL_INPUTS];
  logic [NP-1:0] s1_reg;
  logic [NP-1:0] s2_reg;
  logic [NP-1:0] s3_reg;
  logic [NP-1:0] in_stable_reg;
  logic [NP-1:0] in_gated;
  logic [NP-1:0] periph_in_reg;
  logic [pfm_pkg::NUM_SEL_INPUTS-1:0] sel_in_reg;

  function automatic logic alias_hit(
    input logic [pfm_pkg::AN_ALIAS_W-1:0] ch);
    alias_hit = ch < pfm_pkg::AN_ALIAS_W'(pfm_pkg::NUM_AN_ALIAS);
  endfunction : alias_hit

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        cfg_reg[i].alt_select_field <= pfm_pkg::PRIMARY_FUNCTION;
        cfg_reg[i].input_buffer_enable <= 1'b0;
        cfg_reg[i].slew_rate_ctrl <= pfm_pkg::SLEW_SLOW;
      end
    end else if (cfg_wr_en) begin
      cfg_reg[cfg_wr_pin] <= cfg_wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < pfm_pkg::NUM_SEL_INPUTS; k++) begin
        sel_reg[k] <= pfm_pkg::PAD_SEL_RESET;
      end
    end else if (sel_wr_en) begin
      sel_reg[sel_wr_idx] <= sel_wr_data;
    end
  end

  // Three stages: glitch on pad counts only when two stages agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      in_stable_reg <= '0;
    end else begin
      s1_reg <= pad_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NP; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          in_stable_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_pin
    pfm_pin_cell u_cell (
      .cfg(cfg_reg[p]),
      .func_present(pfm_pkg::FUNC_PRESENT[p*NF +: NF]),
      .input_only(pfm_pkg::INPUT_ONLY_MASK[p]),
      .func_out(func_out[p*NF +: NF]),
      .pad_in_sync(in_stable_reg[p]),
      .pad_out(pad_out[p]),
      .pad_oe_n(pad_oe_n[p]),
      .pad_slew_medium(pad_slew_medium[p]),
      .pad_in_gated(in_gated[p])
    );

    a_pin_reset_primary: assert property (
      @(posedge ref_clk)
      $fell(rst) |->
      cfg_reg[p].alt_select_field == pfm_pkg::PRIMARY_FUNCTION)
      else $error("pin left off primary after reset");

    a_pin_empty_quiet: assert property (
      @(posedge ref_clk) disable iff (rst)
      !pfm_pkg::FUNC_PRESENT[p*NF + 32'(cfg_reg[p].alt_select_field)]
      |-> pad_oe_n[p])
      else $error("empty code drives pad");

    a_pin_slew_map: assert property (
      @(posedge ref_clk) disable iff (rst)
      pad_slew_medium[p] == (!pfm_pkg::INPUT_ONLY_MASK[p] &&
      cfg_reg[p].slew_rate_ctrl == pfm_pkg::SLEW_MEDIUM))
      else $error("slew bit not applied");

    a_pin_sync_agree: assert property (
      @(posedge ref_clk) disable iff (rst)
      in_stable_reg[p] != $past(in_stable_reg[p]) |->
      in_stable_reg[p] == $past(s3_reg[p]) &&
      $past(s2_reg[p]) == $past(s3_reg[p]))
      else $error("filter took unsettled level");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periph_in_reg <= '0;
      sel_in_reg <= '0;
    end else begin
      periph_in_reg <= in_gated;
      for (int k = 0; k < pfm_pkg::NUM_SEL_INPUTS; k++) begin
        sel_in_reg[k] <= in_gated[sel_reg[k]];
      end
    end
  end
  assign periph_in = periph_in_reg;
  assign sel_periph_in = sel_in_reg;

  assign adc2_alias_valid = alias_hit(adc2_channel);
  assign adc1_channel = adc2_alias_valid ?
    pfm_pkg::AN_ALIAS_W'(pfm_pkg::AN_ALIAS_BASE + adc2_channel) : '0;

  a_reset_primary: assert property (@(posedge ref_clk)
    $fell(rst) |-> cfg_reg[0].alt_select_field == pfm_pkg::PRIMARY_FUNCTION)
    else $error("pin not primary after reset");

  a_input_only_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pad_oe_n & pfm_pkg::INPUT_ONLY_MASK) == pfm_pkg::INPUT_ONLY_MASK)
    else $error("input-only pin drives");

  a_unassigned_off: assert property (
    @(posedge ref_clk) disable iff (rst)
    !pfm_pkg::FUNC_PRESENT[2*NF + 32'(cfg_reg[2].alt_select_field)]
    |-> pad_oe_n[2])
    else $error("unassigned code drives");

  a_select_follows: assert property (
    @(posedge ref_clk) disable iff (rst)
    !pad_oe_n[0] |-> pad_out[0] ==
    func_out[cfg_reg[0].alt_select_field].out_val)
    else $error("wrong function selected");

  a_output_only: assert property (
    @(posedge ref_clk) disable iff (rst)
    !func_out[NF + 32'(cfg_reg[1].alt_select_field)].out_en
    |-> pad_oe_n[1])
    else $error("pad driven without enable");

  sequence s_ibe_held;
    cfg_reg[3].input_buffer_enable ##1 cfg_reg[3].input_buffer_enable;
  endsequence : s_ibe_held

  a_ibe_passes: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_ibe_held |-> periph_in[3] == $past(in_stable_reg[3]))
    else $error("input not passed");

  a_ibe_blocks: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(cfg_reg[5].input_buffer_enable) |-> !periph_in[5])
    else $error("input passed without buffer enable");

  a_slew_bit: assert property (
    @(posedge ref_clk) disable iff (rst)
    pad_slew_medium[0] == cfg_reg[0].slew_rate_ctrl)
    else $error("slew mismatch");

  a_sel_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    ##1 sel_periph_in[0] == $past(in_gated[sel_reg[0]]))
    else $error("pad select wrong source");

  a_sel_route_hi: assert property (
    @(posedge ref_clk) disable iff (rst)
    ##1 sel_periph_in[1] == $past(in_gated[sel_reg[1]]))
    else $error("second pad select wrong source");

  a_broadcast_all: assert property (
    @(posedge ref_clk) disable iff (rst)
    ##1 periph_in == $past(in_gated))
    else $error("pad input not broadcast");

  a_alias_map: assert property (
    @(posedge ref_clk) disable iff (rst)
    adc2_channel == 4'h1 |-> adc1_channel == 4'h7)
    else $error("alias channel wrong");

  a_alias_outside: assert property (
    @(posedge ref_clk) disable iff (rst)
    adc2_channel >= pfm_pkg::AN_ALIAS_W'(pfm_pkg::NUM_AN_ALIAS)
    |-> !adc2_alias_valid && adc1_channel == '0)
    else $error("alias outside range");
endmodule : pfm_pad_mux
`default_nettype wire

//--- bench/pfm_periph_model.sv
/*
  Partner model: peripheral output functions and the package pins.
  Assumes the bench supplies the stimulus word; pins have no pulls.
*/
`timescale 1ns/1ps
`default_nettype none
module pfm_periph_model (
  input wire logic [63:0] stim,
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  output var pfm_pkg::pfm_func_out_t [31:0] func_out,
  output logic [7:0] pad_in
);
  // Every peripheral offers a function on every code
  assign func_out = stim;
  // Driven pad wins, else the outside level
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_lvl);
endmodule : pfm_periph_model
`default_nettype wire

//--- bench/pfm_pad_mux_tb.sv
/*
  Self-checking bench for the pad function multiplexer.
  Assumes the partner model drives function outputs and pins.
*/
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_mux_tb;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic cfg_wr_en = 1'h0;
  logic [2:0] cfg_wr_pin = 3'h0;
  pfm_pkg::pfm_pad_cfg_t cfg_wr_data = '0;
  logic sel_wr_en = 1'h0;
  logic sel_wr_idx = 1'h0;
  logic [2:0] sel_wr_data = 3'h0;
  logic [63:0] stim = 64'h0;
  logic [7:0] ext = 8'h0;
  logic [3:0] adc2_channel = 4'h0;
  pfm_pkg::pfm_func_out_t [31:0] func_out;
  logic [7:0] pad_in, pad_out, pad_oe_n, pad_slew_medium, periph_in;
  logic [1:0] sel_periph_in;
  logic adc2_alias_valid;
  logic [3:0] adc1_channel;
  pfm_pkg::pfm_pad_cfg_t cm [8];
  logic [2:0] sm [2];
  int miscompares = 0;
  int tests_run = 0;

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  pfm_pad_mux i_pfm_pad_mux (.ref_clk, .rst, .cfg_wr_en, .cfg_wr_pin,
    .cfg_wr_data, .sel_wr_en, .sel_wr_idx, .sel_wr_data, .func_out,
    .pad_in, .pad_out, .pad_oe_n, .pad_slew_medium, .periph_in,
    .sel_periph_in, .adc2_channel, .adc2_alias_valid, .adc1_channel);
  pfm_periph_model i_pfm_periph_model (.stim, .ext_lvl(ext), .pad_out,
    .pad_oe_n, .func_out, .pad_in);

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  function int ix(int p);
    return p * 4 + int'(cm[p].alt_select_field);
  endfunction : ix

  task check_pins;
    logic [7:0] d, o, s;
    for (int p = 0; p < 8; p++) begin
      d[p] = stim[2*ix(p)] & pfm_pkg::FUNC_PRESENT[ix(p)]
        & ~pfm_pkg::INPUT_ONLY_MASK[p];
      o[p] = d[p] & stim[2*ix(p)+1];
      s[p] = cm[p].slew_rate_ctrl & ~pfm_pkg::INPUT_ONLY_MASK[p];
    end
    chk(pad_oe_n, ~d);
    chk(pad_out, o);
    chk(pad_slew_medium, s);
  endtask : check_pins

  task wr_cfg(input int p, input pfm_pkg::pfm_pad_cfg_t v);
    @(negedge ref_clk);
    cfg_wr_en = 1'h1;
    cfg_wr_pin = 3'(p);
    cfg_wr_data = v;
    @(negedge ref_clk);
    cfg_wr_en = 1'h0;
    cm[p] = v;
  endtask : wr_cfg

  task wr_sel(input int k, input logic [2:0] v);
    @(negedge ref_clk);
    sel_wr_en = 1'h1;
    sel_wr_idx = 1'(k);
    sel_wr_data = v;
    @(negedge ref_clk);
    sel_wr_en = 1'h0;
    sm[k] = v;
  endtask : wr_sel

  initial begin
    logic [7:0] g;
    void'($urandom(32'h851ec036));
    stim = {$urandom, $urandom};
    for (int r = 0; r < 2; r++) begin
      for (int p = 0; p < 8; p++) cm[p] = '0;
      for (int k = 0; k < 2; k++) sm[k] = 3'h0;
      rst = 1'h1;
      repeat (16) @(negedge ref_clk);
      rst = 1'h0;
      check_pins;
      chk(periph_in, 8'h0);
      for (int i = 0; i < 32; i++) begin
        stim = {$urandom, $urandom};
        wr_cfg(i / 4, {2'(i % 4), 2'($urandom)});
        check_pins;
      end
    end
    stim = 64'h0;
    repeat (8) begin
      ext = 8'($urandom);
      for (int p = 0; p < 8; p++) wr_cfg(p, 4'($urandom));
      for (int k = 0; k < 2; k++) wr_sel(k, 3'($urandom));
      repeat (6) @(negedge ref_clk);
      for (int p = 0; p < 8; p++) g[p] = ext[p] & cm[p].input_buffer_enable;
      chk(periph_in, g);
      chk({6'h0, sel_periph_in}, {6'h0, g[sm[1]], g[sm[0]]});
    end
    for (int c = 0; c < 16; c++) begin
      @(negedge ref_clk);
      adc2_channel = 4'(c);
      #1;
      chk({7'h0, adc2_alias_valid}, 8'(c < 2));
      chk({4'h0, adc1_channel}, 8'(c < 2 ? 6 + c : 0));
    end
    wrap_up;
  end

  // Cuts a hang short well past the longest sequence
  initial begin
    #1000000;
    miscompares++;
    wrap_up;
  end
endmodule : pfm_pad_mux_tb
`default_nettype wire
